/* File: hw/awc_conv_seq.sv */
/*
 * Conversion sequencer: one start cycle, a run of converter clocks, then
 * one finish cycle that carries the end-of-conversion pulse.
 * Assumes start is a synchronous pulse and ce freezes the sequence.
 */
`timescale 1ns/10ps
`default_nettype none

module awc_conv_seq
   import awc_pkg::*;
#(
   parameter int DIV_W    = 5,
   parameter int SAR_CLKS = 13
) (
   input  wire logic             clk,     // System clock.
   input  wire logic             arst_n,  // Asynchronous reset, active low.
   input  wire logic             ce,      // Clock enable.
   input  wire logic             start,   // Start request pulse.
   input  wire logic [DIV_W-1:0] div,     // Converter clock divider minus one.
   output logic                  busy,    // Conversion in progress.
   output logic                  eoc      // End of conversion, one cycle.
);

   localparam int BIT_W = $clog2(SAR_CLKS);

   awc_seq_e         state_q, state_d;
   logic [DIV_W-1:0] div_q, div_d;
   logic [DIV_W-1:0] pre_q, pre_d;
   logic [BIT_W-1:0] bit_q, bit_d;

   always_comb begin
      state_d = state_q;
      div_d   = div_q;
      pre_d   = pre_q;
      bit_d   = bit_q;
      case (state_q)
         AWC_IDLE: begin
            if (start) begin
               state_d = AWC_START;
               div_d   = div;
            end
         end
         AWC_START: begin
            state_d = AWC_CONV;  // [R08]
            pre_d   = '0;
            bit_d   = '0;
         end
         AWC_CONV: begin
            if (pre_q == div_q) begin
               pre_d = '0;
               if (bit_q == BIT_W'(SAR_CLKS - 1)) begin
                  state_d = AWC_FINISH;  // [R07]
               end else begin
                  bit_d = bit_q + BIT_W'(1);
               end
            end else begin
               pre_d = pre_q + DIV_W'(1);
            end
         end
         AWC_FINISH: begin
            state_d = AWC_IDLE;  // [R08]
         end
         default: begin
            state_d = AWC_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= AWC_IDLE;
         div_q   <= '0;
         pre_q   <= '0;
         bit_q   <= '0;
      end else if (ce) begin
         state_q <= state_d;
         div_q   <= div_d;
         pre_q   <= pre_d;
         bit_q   <= bit_d;
      end
   end

   assign busy = state_q != AWC_IDLE;
   assign eoc  = state_q == AWC_FINISH;

   logic [9:0] cyc_q;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cyc_q <= '0;
      end else if (!busy) begin
         cyc_q <= '0;
      end else if (ce) begin
         cyc_q <= cyc_q + 10'h001;
      end
   end

   AST_CONV_LEN: assert property (@(posedge clk) disable iff (!arst_n)  // [R07] [R08]
      eoc |-> cyc_q == 10'(SAR_CLKS * (int'(div_q) + 1) + 1))
      else $error("conversion length differs from converter clocks plus two");

   AST_EOC_PULSE: assert property (@(posedge clk) disable iff (!arst_n)  // [R13]
      ce && eoc |=> !eoc)
      else $error("end of conversion lasted more than one cycle");

   COV_CONV_DONE: cover property (@(posedge clk) disable iff (!arst_n)
      ce && state_q == AWC_START ##[1:420] eoc);

endmodule // awc_conv_seq

`default_nettype wire

/* File: hw/awc_top.sv */
/*
 * Window comparator for a successive-approximation converter: limit
 * registers, conversion timing, sticky match flag, interrupt and a simple
 * register port.
 * Assumes the converter delivers its accumulated result word on conv_data
 * and holds it stable in the end-of-conversion cycle.
 */
// Implementation choice: the plain strobed port.
// Behaviour
// R01: The upper limit low byte is an 8-bit read-write register that resets to all ones.
// R02: The lower limit high byte is an 8-bit read-write register that resets to zero.
// R03: The lower limit low byte is an 8-bit read-write register that resets to zero.
// R04: With the lower limit above the upper one, a match needs upper < result < lower.
// R05: With the upper limit above the lower one, a match needs result < lower or > upper.
// R06: A single-ended result is compared as an unsigned integer.
// R07: A conversion takes thirteen converter clocks before its result is compared.
// R08: Each conversion spends two extra system clocks to start and to finish.
// R09: Every new result is compared against the limits and a match is signalled.
// R10: Software clears the match flag; hardware only ever sets it.
// R11: The upper limit high byte is a read-write register forming a 16-bit word with its low byte.
// R12: The limits are compared with the result word as it stands, without realignment.
// R13: The match flag is set in the same cycle as the end-of-conversion result is stored.
`timescale 1ns/10ps
`default_nettype none
`include "awc_cfg.svh"

module awc_top
   import awc_pkg::*;
#(
   parameter int DIV_W    = 5,
   parameter int SAR_CLKS = `AWC_CONV_SAR_CLKS
) (
   input  wire logic         clk,         // System clock, 200 MHz.
   input  wire logic         arst_n,      // Asynchronous reset, active low.
   input  wire logic         ce,          // Clock enable, freezes all state.
   input  wire awc_bus_req_s bus_req,     // Register port request.
   output logic [7:0]        rd_data,     // Read data, cycle after the read.
   input  wire logic         conv_start,  // External conversion start pulse.
   input  wire awc_word_t    conv_data,   // Converter result word.
   output logic              conv_busy,   // Conversion in progress.
   output logic              conv_done,   // Result stored, one cycle.
   output logic              win_irq      // Level interrupt.
);

   function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
      hit = addr == ofs;
   endfunction

   awc_limits_s      lim_q, lim_d;
   awc_word_t        result_q, result_d;
   logic [1:0]       status_q, status_d;
   logic [1:0]       mask_q, mask_d;
   logic             en_q, en_d;
   logic [DIV_W-1:0] div_q, div_d;
   logic [7:0]       rdata_q, rdata_d;

   logic       wr;
   logic       rd;
   logic       seq_start;
   logic       seq_eoc;
   logic       match;
   logic [1:0] st_set;
   logic [1:0] st_clr;

   assign wr = ce && bus_req.we;
   assign rd = ce && bus_req.re;

   awc_window_cmp u_cmp (
      .word   (conv_data),
      .limits (lim_q),
      .match  (match)
   );

   awc_conv_seq #(
      .DIV_W    (DIV_W),
      .SAR_CLKS (SAR_CLKS)
   ) u_seq (
      .clk    (clk),
      .arst_n (arst_n),
      .ce     (ce),
      .start  (seq_start),
      .div    (div_q),
      .busy   (conv_busy),
      .eoc    (seq_eoc)
   );

   // Starts while disabled or busy are dropped.
   always_comb begin
      seq_start = en_q && !conv_busy &&
                  (conv_start ||
                   (wr && hit(bus_req.addr, `AWC_OFS_CTRL) &&
                    bus_req.wdata[`AWC_CTRL_START_BIT]));
   end

   always_comb begin
      lim_d    = lim_q;
      mask_d   = mask_q;
      en_d     = en_q;
      div_d    = div_q;
      result_d = result_q;
      if (wr) begin
         if (hit(bus_req.addr, `AWC_OFS_UPPER_LO)) begin
            lim_d.upper[7:0] = bus_req.wdata;  // [R01]
         end
         if (hit(bus_req.addr, `AWC_OFS_UPPER_HI)) begin
            lim_d.upper[15:8] = bus_req.wdata;  // [R11]
         end
         if (hit(bus_req.addr, `AWC_OFS_LOWER_LO)) begin
            lim_d.lower[7:0] = bus_req.wdata;  // [R03]
         end
         if (hit(bus_req.addr, `AWC_OFS_LOWER_HI)) begin
            lim_d.lower[15:8] = bus_req.wdata;  // [R02]
         end
         if (hit(bus_req.addr, `AWC_OFS_MASK)) begin
            mask_d = bus_req.wdata[1:0];
         end
         if (hit(bus_req.addr, `AWC_OFS_CTRL)) begin
            en_d  = bus_req.wdata[`AWC_CTRL_EN_BIT];
            div_d = bus_req.wdata[`AWC_CTRL_DIV_MSB -: DIV_W];
         end
      end
      if (seq_eoc) begin
         result_d = conv_data;  // [R09]
      end
   end

   // Hardware sets win over a software clear in the same cycle.
   always_comb begin
      st_set = '0;
      st_set[`AWC_ST_EOC_BIT] = seq_eoc;
      st_set[`AWC_ST_WIN_BIT] = seq_eoc && match;  // [R09] [R13]
      st_clr = '0;
      if (wr && hit(bus_req.addr, `AWC_OFS_STATUS)) begin
         st_clr = bus_req.wdata[1:0];  // [R10]
      end
      status_d = (status_q & ~st_clr) | st_set;
   end

   always_comb begin
      rdata_d = 8'h00;
      if (rd) begin
         case (bus_req.addr)
            `AWC_OFS_UPPER_LO: rdata_d = lim_q.upper[7:0];  // [R01]
            `AWC_OFS_UPPER_HI: rdata_d = lim_q.upper[15:8];  // [R11]
            `AWC_OFS_LOWER_LO: rdata_d = lim_q.lower[7:0];  // [R03]
            `AWC_OFS_LOWER_HI: rdata_d = lim_q.lower[15:8];  // [R02]
            `AWC_OFS_STATUS:   rdata_d = {6'h00, status_q};
            `AWC_OFS_MASK:     rdata_d = {6'h00, mask_q};
            `AWC_OFS_CTRL: begin
               rdata_d = 8'h00;
               rdata_d[`AWC_CTRL_EN_BIT]    = en_q;
               rdata_d[`AWC_CTRL_START_BIT] = conv_busy;
               rdata_d[`AWC_CTRL_DIV_MSB -: DIV_W] = div_q;
            end
            default:           rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         lim_q.upper <= {`AWC_RST_UPPER_HI, `AWC_RST_UPPER_LO};  // [R01]
         lim_q.lower <= {`AWC_RST_LOWER_HI, `AWC_RST_LOWER_LO};  // [R02] [R03]
         result_q    <= '0;
         status_q    <= `AWC_RST_STATUS;
         mask_q      <= `AWC_RST_MASK;
         en_q        <= `AWC_RST_CTRL_EN;
         div_q       <= `AWC_RST_CTRL_DIV;
         rdata_q     <= 8'h00;
      end else if (ce) begin
         lim_q    <= lim_d;
         result_q <= result_d;
         status_q <= status_d;
         mask_q   <= mask_d;
         en_q     <= en_d;
         div_q    <= div_d;
         rdata_q  <= rdata_d;
      end
   end

   assign rd_data   = rdata_q;
   assign conv_done = seq_eoc;
   assign win_irq   = |(status_q & mask_q);

   // Checks.
   logic clr_win;
   assign clr_win = wr && hit(bus_req.addr, `AWC_OFS_STATUS) &&
                    bus_req.wdata[`AWC_ST_WIN_BIT];

   AST_INSIDE_MATCH: assert property (@(posedge clk) disable iff (!arst_n)  // [R04]
      ce && seq_eoc && lim_q.lower > lim_q.upper &&
      conv_data > lim_q.upper && conv_data < lim_q.lower
      |=> status_q[`AWC_ST_WIN_BIT])
      else $error("inside-window result did not raise the match flag");

   AST_OUTSIDE_MATCH: assert property (@(posedge clk) disable iff (!arst_n)  // [R05]
      ce && seq_eoc && lim_q.lower <= lim_q.upper &&
      (conv_data > lim_q.upper || conv_data < lim_q.lower)
      |=> status_q[`AWC_ST_WIN_BIT])
      else $error("outside-window result did not raise the match flag");

   AST_NO_FALSE_MATCH: assert property (@(posedge clk) disable iff (!arst_n)  // [R04] [R05]
      ce && seq_eoc && !clr_win && !status_q[`AWC_ST_WIN_BIT] &&
      !(lim_q.lower > lim_q.upper ?
        (conv_data > lim_q.upper && conv_data < lim_q.lower) :
        (conv_data > lim_q.upper || conv_data < lim_q.lower))
      |=> !status_q[`AWC_ST_WIN_BIT])
      else $error("match flag set by a result outside the condition");

   AST_FLAG_ONLY_ON_EOC: assert property (@(posedge clk) disable iff (!arst_n)  // [R13]
      $rose(status_q[`AWC_ST_WIN_BIT]) |-> $past(seq_eoc))
      else $error("match flag rose without an end of conversion");

   AST_FLAG_STICKY: assert property (@(posedge clk) disable iff (!arst_n)  // [R10]
      status_q[`AWC_ST_WIN_BIT] && !clr_win |=> status_q[`AWC_ST_WIN_BIT])
      else $error("match flag dropped without a software clear");

   AST_SET_WINS: assert property (@(posedge clk) disable iff (!arst_n)  // [R10] [R13]
      clr_win && seq_eoc && match |=> status_q[`AWC_ST_WIN_BIT])
      else $error("simultaneous clear lost a new match");

   AST_RESULT_STORED: assert property (@(posedge clk) disable iff (!arst_n)  // [R09] [R13]
      ce && seq_eoc |=> result_q == $past(conv_data) && status_q[`AWC_ST_EOC_BIT])
      else $error("result word not stored at end of conversion");

   AST_READ_LIMITS: assert property (@(posedge clk) disable iff (!arst_n)  // [R01] [R02] [R03] [R11]
      rd && !wr && bus_req.addr inside {`AWC_OFS_UPPER_LO, `AWC_OFS_UPPER_HI,
                                        `AWC_OFS_LOWER_LO, `AWC_OFS_LOWER_HI}
      |=> rd_data == ($past(bus_req.addr) == `AWC_OFS_UPPER_LO ? lim_q.upper[7:0] :
                      $past(bus_req.addr) == `AWC_OFS_UPPER_HI ? lim_q.upper[15:8] :
                      $past(bus_req.addr) == `AWC_OFS_LOWER_LO ? lim_q.lower[7:0] :
                                                                 lim_q.lower[15:8]))
      else $error("limit register read back a wrong value");

   AST_WRITE_LIMIT: assert property (@(posedge clk) disable iff (!arst_n)  // [R01] [R11]
      wr && hit(bus_req.addr, `AWC_OFS_UPPER_HI) ##1
      ce && bus_req.we && hit(bus_req.addr, `AWC_OFS_UPPER_LO)
      |=> lim_q.upper == {$past(bus_req.wdata, 2), $past(bus_req.wdata)})
      else $error("upper limit bytes did not form one word");

   AST_RDATA_ONE_CYCLE: assert property (@(posedge clk) disable iff (!arst_n)
      $past(ce) && !$past(bus_req.re) |-> rd_data == 8'h00)
      else $error("read data outside the cycle after a read");

   AST_IRQ_LEVEL: assert property (@(posedge clk) disable iff (!arst_n)
      ce && seq_eoc && match && mask_q[`AWC_ST_WIN_BIT] && !(wr &&
      hit(bus_req.addr, `AWC_OFS_MASK)) |=> win_irq)
      else $error("unmasked match did not raise the interrupt");

   AST_WIN_CLEARED: assert property (@(posedge clk) disable iff (!arst_n)  // [R10]
      clr_win && !(seq_eoc && match) |=> !status_q[`AWC_ST_WIN_BIT])
      else $error("match flag survived a software clear");

   AST_IRQ_CLEARED: assert property (@(posedge clk) disable iff (!arst_n)  // [R10]
      clr_win && mask_q == 2'b01 && !(seq_eoc && match) |=> !win_irq)
      else $error("interrupt stayed high after its flag was cleared");

   AST_MASK_WRITE: assert property (@(posedge clk) disable iff (!arst_n)
      wr && hit(bus_req.addr, `AWC_OFS_MASK) |=> mask_q == $past(bus_req.wdata[1:0]))
      else $error("mask register did not take the written value");

   AST_CE_FREEZE: assert property (@(posedge clk) disable iff (!arst_n)
      !ce |=> $stable(lim_q) && $stable(status_q) && $stable(mask_q) && $stable(rd_data))
      else $error("state moved while the clock enable was low");

   AST_START_REFUSED: assert property (@(posedge clk) disable iff (!arst_n)
      ce && !en_q && !conv_busy |=> !conv_busy)
      else $error("conversion started while disabled");

   AST_START_TAKEN: assert property (@(posedge clk) disable iff (!arst_n)  // [R08]
      ce && seq_start |=> conv_busy && !conv_done)
      else $error("accepted start did not begin a conversion");

   AST_CTRL_BUSY_READ: assert property (@(posedge clk) disable iff (!arst_n)
      rd && hit(bus_req.addr, `AWC_OFS_CTRL)
      |=> rd_data[`AWC_CTRL_START_BIT] == $past(conv_busy))
      else $error("control read did not show the busy state");

   AST_WRITE_LOWER_LO: assert property (@(posedge clk) disable iff (!arst_n)  // [R03]
      wr && hit(bus_req.addr, `AWC_OFS_LOWER_LO)
      |=> lim_q.lower[7:0] == $past(bus_req.wdata))
      else $error("lower limit low byte did not take the written value");

   AST_WRITE_LOWER_HI: assert property (@(posedge clk) disable iff (!arst_n)  // [R02]
      wr && hit(bus_req.addr, `AWC_OFS_LOWER_HI)
      |=> lim_q.lower[15:8] == $past(bus_req.wdata))
      else $error("lower limit high byte did not take the written value");

   AST_UNMAPPED_READ: assert property (@(posedge clk) disable iff (!arst_n)
      rd && !(bus_req.addr inside {[`AWC_OFS_UPPER_LO:`AWC_OFS_CTRL]})
      |=> rd_data == 8'h00)
      else $error("unmapped read returned non-zero data");

   COV_INSIDE: cover property (@(posedge clk) disable iff (!arst_n)
      seq_eoc && match && lim_q.lower > lim_q.upper);

   COV_OUTSIDE: cover property (@(posedge clk) disable iff (!arst_n)
      seq_eoc && match && lim_q.lower <= lim_q.upper);

   COV_SET_AND_CLEAR: cover property (@(posedge clk) disable iff (!arst_n)
      clr_win && seq_eoc && match);

   COV_IRQ: cover property (@(posedge clk) disable iff (!arst_n)
      $rose(win_irq));

endmodule // awc_top

`default_nettype wire

/* File: hw/awc_window_cmp.sv */
/*
 * Combinational window test of one result word against two limits.
 * Assumes the result word and the limits share one justification.
 */
`timescale 1ns/10ps
`default_nettype none

module awc_window_cmp
   import awc_pkg::*;
(
   input  wire awc_word_t   word,    // Result word under test.
   input  wire awc_limits_s limits,  // Upper and lower comparison limits.
   output logic             match    // Window condition met.
);

   function automatic logic in_window(input awc_word_t w, input awc_limits_s l);
      logic above;
      logic below;
      above = w > l.upper;
      below = w < l.lower;
      if (l.lower > l.upper) begin
         in_window = above && below;  // [R04]
      end else begin
         in_window = above || below;  // [R05]
      end
   endfunction

   // The word is compared whole and unsigned, as it stands.
   always_comb begin
      match = in_window(word, limits);  // [R06] [R12]
   end

endmodule // awc_window_cmp

`default_nettype wire

/* File: inc/awc_cfg.svh */
/*
 * Register offsets, reset values, field positions and timing counts of the
 * converter window comparator.
 * Assumes an 8-bit register port with byte-wide registers.
 */
`ifndef AWC_CFG_SVH
`define AWC_CFG_SVH

`define AWC_OFS_UPPER_LO    8'hc3
`define AWC_OFS_UPPER_HI    8'hc4
`define AWC_OFS_LOWER_LO    8'hc5
`define AWC_OFS_LOWER_HI    8'hc6
`define AWC_OFS_STATUS      8'hc7
`define AWC_OFS_MASK        8'hc8
`define AWC_OFS_CTRL        8'hc9

`define AWC_RST_UPPER_LO    8'hff
`define AWC_RST_UPPER_HI    8'hff
`define AWC_RST_LOWER_LO    8'h00
`define AWC_RST_LOWER_HI    8'h00
`define AWC_RST_STATUS      2'h0
`define AWC_RST_MASK        2'h0
`define AWC_RST_CTRL_EN     1'h0
`define AWC_RST_CTRL_DIV    5'h1f

`define AWC_ST_WIN_BIT      0
`define AWC_ST_EOC_BIT      1
`define AWC_CTRL_EN_BIT     7
`define AWC_CTRL_START_BIT  6
`define AWC_CTRL_DIV_MSB    4

`define AWC_CONV_SAR_CLKS   13
`define AWC_EDGE_SYS_CLKS   2

`endif

/* File: inc/awc_pkg.sv */
/*
 * Types shared by the converter window comparator modules.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package awc_pkg;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       we;
      logic       re;
   } awc_bus_req_s;

   typedef logic [15:0] awc_word_t;

   typedef struct packed {
      awc_word_t upper;
      awc_word_t lower;
   } awc_limits_s;

   typedef enum logic [1:0] {
      AWC_IDLE   = 2'b00,
      AWC_START  = 2'b01,
      AWC_CONV   = 2'b11,
      AWC_FINISH = 2'b10
   } awc_seq_e;

endpackage

/* File: sim/awc_conv_model.sv */
/*
 * Model of the converter result path: it issues a start pulse, presents the
 * result word during the conversion and measures the conversion timing.
 * Assumes one caller of run() at a time and the design on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none

module awc_conv_model
   import awc_pkg::*;
(
   input  wire logic     clk,         // System clock.
   input  wire logic     conv_busy,   // Conversion in progress.
   input  wire logic     conv_done,   // Result stored, one cycle.
   output var logic      conv_start,  // Start pulse.
   output var awc_word_t conv_data    // Result word.
);

   awc_word_t val_q;

   initial begin
      conv_start = 1'b0;
      val_q      = 16'h0000;
   end

   // Outside a conversion the word is not valid, so the inverse is shown.
   assign conv_data = conv_busy ? val_q : ~val_q;

   task automatic run(input awc_word_t v, output int n, output int nb);
      @(posedge clk);
      val_q      <= v;
      conv_start <= 1'b1;
      @(posedge clk);
      conv_start <= 1'b0;
      n  = 0;
      nb = 0;
      #1;
      while (conv_done !== 1'b1 && n < 1000) begin
         if (conv_busy === 1'b1) begin
            nb++;
         end
         @(posedge clk);
         n++;
         #1;
      end
      if (conv_busy === 1'b1) begin
         nb++;
      end
      @(posedge clk);
      #1;
   endtask

endmodule // awc_conv_model

`default_nettype wire

/* File: sim/awc_top_bench.sv */
/*
 * Self-checking bench of the window comparator top.
 * Assumes the converter model drives the start pulse and the result word.
 */
`timescale 1ns/10ps
`default_nettype none
`include "awc_cfg.svh"

module awc_top_bench;
   import awc_pkg::*;

   logic         clk;
   logic         arst_n;
   logic         ce;
   awc_bus_req_s bus_req;
   logic [7:0]   rd_data;
   logic         conv_start;
   awc_word_t    conv_data;
   logic         conv_busy;
   logic         conv_done;
   logic         win_irq;
   int           bad_count;
   int           compares;
   int           cycles = 0;

   awc_top dut (
      .clk(clk), .arst_n(arst_n), .ce(ce), .bus_req(bus_req), .rd_data(rd_data),
      .conv_start(conv_start), .conv_data(conv_data), .conv_busy(conv_busy),
      .conv_done(conv_done), .win_irq(win_irq)
   );

   awc_conv_model model (
      .clk(clk), .conv_busy(conv_busy), .conv_done(conv_done),
      .conv_start(conv_start), .conv_data(conv_data)
   );

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         bad_count++;
         stop_test();
      end
   end

   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      bus_req <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
      @(posedge clk);
      bus_req <= '0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      bus_req <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
      @(posedge clk);
      bus_req <= '0;
      #1;
      check({8'h00, rd_data}, {8'h00, exp}, "register read");
   endtask

   task automatic set_lim(input awc_word_t upper, input awc_word_t lower);
      wr(`AWC_OFS_UPPER_LO, upper[7:0]);
      wr(`AWC_OFS_UPPER_HI, upper[15:8]);
      wr(`AWC_OFS_LOWER_LO, lower[7:0]);
      wr(`AWC_OFS_LOWER_HI, lower[15:8]);
   endtask

   task automatic conv_chk(input awc_word_t v, input logic hit, input int div);
      int n;
      int nb;
      wr(`AWC_OFS_STATUS, 8'h03);
      model.run(v, n, nb);
      check(16'(n), 16'(13 * (div + 1) + 1), "done delay");
      check(16'(nb), 16'(13 * (div + 1) + 2), "busy length");
      rd_chk(`AWC_OFS_STATUS, {6'h00, 1'b1, hit});
   endtask

   task automatic test_reset();
      rd_chk(`AWC_OFS_UPPER_LO, 8'hff);
      rd_chk(`AWC_OFS_UPPER_HI, 8'hff);
      rd_chk(`AWC_OFS_LOWER_LO, 8'h00);
      rd_chk(`AWC_OFS_LOWER_HI, 8'h00);
      rd_chk(`AWC_OFS_STATUS, 8'h00);
      check({15'h0000, win_irq}, 16'h0000, "irq after reset");
      $display("test reset done");
   endtask

   task automatic test_rw();
      for (int i = 0; i < 4; i++) begin
         wr(8'hc3 + 8'(i), 8'h5a ^ 8'(i));
      end
      for (int i = 0; i < 4; i++) begin
         rd_chk(8'hc3 + 8'(i), 8'h5a ^ 8'(i));
      end
      // Back-to-back high then low byte of the upper limit.
      @(posedge clk);
      bus_req <= '{addr: `AWC_OFS_UPPER_HI, wdata: 8'h12, we: 1'b1, re: 1'b0};
      @(posedge clk);
      bus_req <= '{addr: `AWC_OFS_UPPER_LO, wdata: 8'h34, we: 1'b1, re: 1'b0};
      @(posedge clk);
      bus_req <= '0;
      rd_chk(`AWC_OFS_UPPER_HI, 8'h12);
      rd_chk(`AWC_OFS_UPPER_LO, 8'h34);
      wr(8'hd0, 8'h77);
      rd_chk(8'hd0, 8'h00);
      $display("test register access done");
   endtask

   task automatic test_inside();
      wr(`AWC_OFS_CTRL, 8'h80);
      set_lim(16'h0100, 16'h0200);
      conv_chk(16'h0100, 1'b0, 0);
      conv_chk(16'h0101, 1'b1, 0);
      conv_chk(16'h01ff, 1'b1, 0);
      conv_chk(16'h0200, 1'b0, 0);
      $display("test inside window done");
   endtask

   task automatic test_outside();
      set_lim(16'h0200, 16'h0100);
      conv_chk(16'h00ff, 1'b1, 0);
      conv_chk(16'h0100, 1'b0, 0);
      conv_chk(16'h0200, 1'b0, 0);
      conv_chk(16'h0201, 1'b1, 0);
      wr(`AWC_OFS_CTRL, 8'h81);
      conv_chk(16'h0fff, 1'b1, 1);
      $display("test outside window done");
   endtask

   task automatic test_irq();
      check({15'h0000, win_irq}, 16'h0000, "irq masked");
      wr(`AWC_OFS_MASK, 8'h01);
      #1;
      check({15'h0000, win_irq}, 16'h0001, "irq on match");
      wr(`AWC_OFS_STATUS, 8'h01);
      #1;
      check({15'h0000, win_irq}, 16'h0000, "irq after clear");
      wr(`AWC_OFS_MASK, 8'h02);
      #1;
      check({15'h0000, win_irq}, 16'h0001, "irq on done");
      wr(`AWC_OFS_STATUS, 8'h02);
      rd_chk(`AWC_OFS_STATUS, 8'h00);
      $display("test interrupt done");
   endtask

   task automatic test_ctrl();
      int n;
      int nb;
      wr(`AWC_OFS_MASK, 8'h01);
      @(posedge clk);
      ce <= 1'b0;
      wr(`AWC_OFS_MASK, 8'h02);
      @(posedge clk);
      ce <= 1'b1;
      rd_chk(`AWC_OFS_MASK, 8'h01);
      wr(`AWC_OFS_CTRL, 8'h80);
      wr(`AWC_OFS_CTRL, 8'hc0);
      rd_chk(`AWC_OFS_CTRL, 8'hc0);
      // The model still shows 0x0fff, outside the window; the clear lands on
      // the end-of-conversion cycle and must lose to the new flags.
      repeat (11) @(posedge clk);
      wr(`AWC_OFS_STATUS, 8'h03);
      rd_chk(`AWC_OFS_STATUS, 8'h03);
      check({15'h0000, win_irq}, 16'h0001, "irq on unmasked match");
      wr(`AWC_OFS_CTRL, 8'h00);
      model.run(16'h0000, n, nb);
      check(16'(nb), 16'h0000, "start taken while disabled");
      $display("test control done");
   endtask

   initial begin
      arst_n    = 1'b0;
      ce        = 1'b1;
      bus_req   = '0;
      bad_count = 0;
      compares  = 0;
      repeat (16) @(posedge clk);
      arst_n <= 1'b1;
      test_reset();
      test_rw();
      test_inside();
      test_outside();
      test_irq();
      test_ctrl();
      stop_test();
   end

endmodule // awc_top_bench

`default_nettype wire
